// ### design/rcadc_top.sv
// rc oscillation converter core: apb registers, two counters, mode decode
// assumes the analogue oscillator network drives rc_osc_clock and that
// every clock-like input is asynchronous to pclk
module rcadc_top
  import rcadc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        base_count_clock,
  input  wire logic        rc_osc_clock,
  input  wire logic        ch0_ext_clock_in,
  input  wire logic        ch1_ext_clock_in,
  output logic             osc_monitor_out,
  output rcadc_pins_s      osc_pins,
  output logic             converter_irq
);

  // --------------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------------
  function automatic logic is_prohibited(input logic [7:0] m);
    return m[`RCADC_OMODE_MSB];
  endfunction : is_prohibited

  // which oscillator pins take part in each mode
  function automatic rcadc_pins_s pins_of(input logic [7:0] m, input logic run);
    rcadc_pins_s p;
    p = '0;
    if (run && !is_prohibited(m)) begin
      unique case (m[2:0])
        3'h1: begin
          p.ch0_ref_res_pin = 1'b1;
          p.ch0_ref_cap_pin = 1'b1;
        end
        3'h2: begin
          p.ch0_sensor_res_pin = 1'b1;
          p.ch0_ref_cap_pin    = 1'b1;
        end
        3'h3: begin
          p.ch0_sensor_res_pin = 1'b1;
          p.ch1_sensor_res_pin = 1'b1;
          p.ch0_ref_cap_pin    = 1'b1;
        end
        3'h4: begin
          p.ch0_ref_res_pin   = 1'b1;
          p.ch0_sensor_rc_pin = 1'b1;
        end
        3'h5: begin
          p.ch1_ref_res_pin = 1'b1;
          p.ch1_ref_cap_pin = 1'b1;
        end
        3'h6: begin
          p.ch1_sensor_res_pin = 1'b1;
          p.ch1_ref_cap_pin    = 1'b1;
        end
        default: begin
          p = '0;
        end
      endcase
    end
    return p;
  endfunction : pins_of

  // --------------------------------------------------------------------------
  // byte lane decode
  // --------------------------------------------------------------------------
  // one-hot byte lane of a counter; zero when the index misses all three
  function automatic logic [2:0] lane_of(input logic [15:0] i, input logic [15:0] base);
    logic [2:0] l;
    l = 3'h0;
    for (int b = 0; b < 3; b++) begin
      l[b] = (i == base + 16'(b));
    end
    return l;
  endfunction : lane_of

  // --------------------------------------------------------------------------
  // synchronisers
  // --------------------------------------------------------------------------
  logic base_lvl;
  logic base_rise;
  logic rc_lvl;
  logic rc_rise;
  logic ext0_lvl;
  logic ext0_rise;
  logic ext1_lvl;
  logic ext1_rise;

  // a count lands two to three pclk after an input edge; each level must last two pclk
  rcadc_sync u_sync_base (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .d       (base_count_clock),
    .lvl     (base_lvl),
    .rise    (base_rise)
  );

  rcadc_sync u_sync_rc (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .d       (rc_osc_clock),
    .lvl     (rc_lvl),
    .rise    (rc_rise)
  );

  rcadc_sync u_sync_ext0 (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .d       (ch0_ext_clock_in),
    .lvl     (ext0_lvl),
    .rise    (ext0_rise)
  );

  rcadc_sync u_sync_ext1 (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .d       (ch1_ext_clock_in),
    .lvl     (ext1_lvl),
    .rise    (ext1_rise)
  );

  // --------------------------------------------------------------------------
  // state and oscillator select
  // --------------------------------------------------------------------------
  rcadc_top_st_s st_q;
  rcadc_top_st_s st_d;

  logic        run;
  logic        osc_lvl;
  logic        osc_rise;
  logic [15:0] idx;
  logic        wr_acc;
  logic        rd_acc;
  logic [2:0]  wr_ref;
  logic [2:0]  wr_osc;
  logic [23:0] ref_count;
  logic [23:0] osc_count;
  logic        ref_ovf;
  logic        osc_ovf;
  logic        sel_ovf;

  assign run = st_q.ctrl[`RCADC_RUN_BIT];

  // one counter pair serves both channels; the mode picks the source
  always_comb begin
    osc_lvl  = rc_lvl;
    osc_rise = rc_rise;
    if (is_prohibited(st_q.mode)) begin
      osc_lvl  = 1'b0;
      osc_rise = 1'b0;
    end else if (st_q.mode[2:0] == `RCADC_OMODE_EXT0) begin
      osc_lvl  = ext0_lvl;
      osc_rise = ext0_rise;
    end else if (st_q.mode[2:0] == `RCADC_OMODE_EXT1) begin
      osc_lvl  = ext1_lvl;
      osc_rise = ext1_rise;
    end
  end

  // --------------------------------------------------------------------------
  // apb decode: one wait state, writes taken when pready is high, reads in the wait cycle
  // --------------------------------------------------------------------------
  assign idx    = paddr[`RCADC_IDX_MSB:`RCADC_IDX_LSB];
  assign wr_acc = psel && penable && st_q.pready && pwrite;
  assign rd_acc = psel && penable && !st_q.pready && !pwrite;

  always_comb begin
    wr_ref = 3'h0;
    wr_osc = 3'h0;
    if (wr_acc) begin
      wr_ref = lane_of(idx, `RCADC_IDX_REF0);
      wr_osc = lane_of(idx, `RCADC_IDX_OSC0);
    end
  end

  // --------------------------------------------------------------------------
  // counters
  // --------------------------------------------------------------------------
  rcadc_counter u_ref_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .inc     (run && base_rise),
    .wr_en   (wr_ref),
    .wr_byte (pwdata[7:0]),
    .count   (ref_count),
    .ovf     (ref_ovf)
  );

  rcadc_counter u_osc_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .inc     (run && osc_rise),
    .wr_en   (wr_osc),
    .wr_byte (pwdata[7:0]),
    .count   (osc_count),
    .ovf     (osc_ovf)
  );

  // the unselected overflow still stops the run but raises no selected event
  assign sel_ovf = st_q.mode[`RCADC_IRQSEL_BIT] ? osc_ovf : ref_ovf;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic [23:0] ref_rd;
    logic [23:0] osc_rd;
    logic        hw_stop;
    logic [1:0]  ev;
    st_d    = st_q;
    ref_rd  = '0;
    osc_rd  = '0;
    hw_stop = 1'b0;
    ev      = 2'h0;

    // held image answers reads while running after a write
    ref_rd = (run && st_q.held_ref) ? st_q.hold_ref : ref_count;
    osc_rd = (run && st_q.held_osc) ? st_q.hold_osc : osc_count;

    // a registered answer keeps every output on a flop, at the cost of one wait state
    st_d.pready  = psel && penable && !st_q.pready;
    st_d.pslverr = 1'b0;
    if (!psel || !penable || st_q.pready) begin
      st_d.prdata = '0;
    end

    // an unmapped index answers with an error, reads zero and changes nothing
    if (psel && penable && !st_q.pready) begin
      unique case (idx)
        `RCADC_IDX_REF0, `RCADC_IDX_REF1, `RCADC_IDX_REF2,
        `RCADC_IDX_OSC0, `RCADC_IDX_OSC1, `RCADC_IDX_OSC2,
        `RCADC_IDX_MODE, `RCADC_IDX_CTRL, `RCADC_IDX_STATUS,
        `RCADC_IDX_IRQ_EN, `RCADC_IDX_IRQ_CLR: begin
          st_d.pslverr = 1'b0;
        end
        default: begin
          st_d.pslverr = 1'b1;
        end
      endcase
    end

    if (rd_acc) begin
      unique case (idx)
        `RCADC_IDX_REF0:   st_d.prdata = {24'h000000, ref_rd[7:0]};
        `RCADC_IDX_REF1:   st_d.prdata = {24'h000000, ref_rd[15:8]};
        `RCADC_IDX_REF2:   st_d.prdata = {24'h000000, ref_rd[23:16]};
        `RCADC_IDX_OSC0:   st_d.prdata = {24'h000000, osc_rd[7:0]};
        `RCADC_IDX_OSC1:   st_d.prdata = {24'h000000, osc_rd[15:8]};
        `RCADC_IDX_OSC2:   st_d.prdata = {24'h000000, osc_rd[23:16]};
        `RCADC_IDX_MODE:   st_d.prdata = {24'h000000, st_q.mode};
        `RCADC_IDX_CTRL:   st_d.prdata = {24'h000000, st_q.ctrl};
        `RCADC_IDX_STATUS: st_d.prdata = {30'h00000000, st_q.status};
        `RCADC_IDX_IRQ_EN: st_d.prdata = {30'h00000000, st_q.irq_en};
        default:           st_d.prdata = '0;
      endcase
    end

    // bytes not written keep what a read shows now, so the image stays coherent
    // counter writes also refresh the image read back during a run
    for (int i = 0; i < 3; i++) begin
      if (wr_ref[i]) begin
        st_d.hold_ref            = ref_rd;
        st_d.hold_ref[i*8 +: 8]  = pwdata[7:0];
        st_d.held_ref            = 1'b1;
      end
      if (wr_osc[i]) begin
        st_d.hold_osc            = osc_rd;
        st_d.hold_osc[i*8 +: 8]  = pwdata[7:0];
        st_d.held_osc            = 1'b1;
      end
    end

    // base clock select bits are stored only; one base input feeds the reference
    if (wr_acc && idx == `RCADC_IDX_MODE) begin
      st_d.mode = pwdata[7:0];
    end
    // only the run bit is kept; the other control bits read back as zero
    if (wr_acc && idx == `RCADC_IDX_CTRL) begin
      st_d.ctrl = {7'h00, pwdata[`RCADC_RUN_BIT]};
    end
    if (wr_acc && idx == `RCADC_IDX_IRQ_EN) begin
      st_d.irq_en = pwdata[1:0];
    end
    if (wr_acc && idx == `RCADC_IDX_IRQ_CLR) begin
      st_d.status = st_q.status & ~pwdata[1:0];
    end

    // overflow stops the run; it wins over a software start in that cycle
    if (run && (ref_ovf || osc_ovf)) begin
      st_d.ctrl[`RCADC_RUN_BIT] = 1'b0;
      hw_stop                   = 1'b1;
    end

    // a finished run releases the held images
    if (!st_d.ctrl[`RCADC_RUN_BIT] && run) begin
      st_d.held_ref = 1'b0;
      st_d.held_osc = 1'b0;
    end

    // events set sticky bits; a set beats a clear in the same cycle
    ev[`RCADC_ST_OVF]  = run && sel_ovf;
    ev[`RCADC_ST_STOP] = hw_stop;
    st_d.status = st_d.status | ev;

    // irq and monitor use next state, so they move in the same edge as status and run
    st_d.irq  = |(st_d.status & st_d.irq_en);
    st_d.mon  = st_d.ctrl[`RCADC_RUN_BIT] && osc_lvl;
    st_d.pins = pins_of(st_d.mode, st_d.ctrl[`RCADC_RUN_BIT]);
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign prdata          = st_q.prdata;
  assign pready          = st_q.pready;
  assign pslverr         = st_q.pslverr;
  assign converter_irq   = st_q.irq;
  assign osc_monitor_out = st_q.mon;
  assign osc_pins        = st_q.pins;

endmodule : rcadc_top

// ### design/rcadc_consts.svh
// constants of the rc oscillation converter: register indices, fields, reset values
// assumes inclusion by the package and by the verification files that decode registers
// Function
// - two channels share one counter pair by time division
// - measure resistance or capacitance by counting an oscillator clock
// - two oscillator channels, two counters, mode and control registers
// - reference counter is 24 bits in three bytes, low byte first
// - oscillator counter is 24 bits in three bytes, low byte first
// - counter byte writes load the counter, reads access the counter
// - counter bytes are 8-bit, read/write, zero after reset
// - while running after a write, reads return the written value
// - once stopped, reads return the accumulated count
// - each channel accepts an external oscillation clock as a mode
// - a monitor output follows the active oscillation waveform
// - run bit 0 starts and stops; overflow or reset clears it
// - mode bit 4 picks reference (0) or oscillator (1) overflow interrupt
// - reference counts base clock, oscillator counts rc clock, only while running
// - mode bits 3-0 pick one of eight modes; top bit set is prohibited
`ifndef RCADC_CONSTS_SVH
`define RCADC_CONSTS_SVH

// --------------------------------------------------------------------------
// register indices (byte address is four times the index)
// --------------------------------------------------------------------------
`define RCADC_IDX_REF0      16'hF300
`define RCADC_IDX_REF1      16'hF301
`define RCADC_IDX_REF2      16'hF302
`define RCADC_IDX_OSC0      16'hF304
`define RCADC_IDX_OSC1      16'hF305
`define RCADC_IDX_OSC2      16'hF306
`define RCADC_IDX_MODE      16'hF308
`define RCADC_IDX_CTRL      16'hF309
`define RCADC_IDX_STATUS    16'hF30A
`define RCADC_IDX_IRQ_EN    16'hF30B
`define RCADC_IDX_IRQ_CLR   16'hF30C

// --------------------------------------------------------------------------
// fields and values
// --------------------------------------------------------------------------
`define RCADC_IDX_LSB       2
`define RCADC_IDX_MSB       17
`define RCADC_RUN_BIT       0
`define RCADC_IRQSEL_BIT    4
`define RCADC_OMODE_MSB     3
`define RCADC_ST_OVF        0
`define RCADC_ST_STOP       1
`define RCADC_CNT_MAX       24'hFFFFFF
`define RCADC_REG_RESET     8'h00
`define RCADC_OMODE_EXT0    3'h0
`define RCADC_OMODE_EXT1    3'h7

`endif

// ### design/rcadc_pkg.sv
// types shared by the rc oscillation converter modules
// assumes rcadc_consts.svh sits beside it
`include "rcadc_consts.svh"

package rcadc_pkg;

  // ------------------------------------------------------------------------
  // pin drive group of both oscillator channels
  // ------------------------------------------------------------------------
  typedef struct packed {
    logic ch0_ref_cap_pin;
    logic ch0_ref_res_pin;
    logic ch0_sensor_res_pin;
    logic ch0_sensor_rc_pin;
    logic ch1_ref_cap_pin;
    logic ch1_ref_res_pin;
    logic ch1_sensor_res_pin;
  } rcadc_pins_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } rcadc_sync_st_s;

  typedef struct packed {
    logic [23:0] hold_ref;
    logic [23:0] hold_osc;
    logic        held_ref;
    logic        held_osc;
    logic [7:0]  mode;
    logic [7:0]  ctrl;
    logic [1:0]  status;
    logic [1:0]  irq_en;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
    logic        mon;
    rcadc_pins_s pins;
  } rcadc_top_st_s;

endpackage : rcadc_pkg

// ### design/rcadc_sync.sv
// two-flop synchroniser with rising edge detect
// assumes d is asynchronous to pclk
module rcadc_sync
  import rcadc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic d,
  output logic      lvl,
  output logic      rise
);

  rcadc_sync_st_s st_q;
  rcadc_sync_st_s st_d;

  // first flop feeds only the second; edges are found on the second
  always_comb begin
    st_d      = st_q;
    st_d.s1   = d;
    st_d.s2   = st_q.s1;
    st_d.prev = st_q.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign lvl  = st_q.s2;
  assign rise = st_q.s2 & ~st_q.prev;

endmodule : rcadc_sync

// ### design/rcadc_counter.sv
// 24-bit counter with per-byte load and overflow pulse
// assumes inc and the write strobes come from pclk logic
module rcadc_counter
  import rcadc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        inc,
  input  wire logic [2:0]  wr_en,
  input  wire logic [7:0]  wr_byte,
  output logic      [23:0] count,
  output logic             ovf
);

  logic [23:0] cnt_q;
  logic [23:0] cnt_d;

  // a loaded byte wins over a count in the same cycle; bytes not written still take the count
  always_comb begin
    cnt_d = cnt_q;
    if (inc) begin
      cnt_d = cnt_q + 24'h000001;
    end
    for (int i = 0; i < 3; i++) begin
      if (wr_en[i]) begin
        cnt_d[i*8 +: 8] = wr_byte;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
    end
  end

  assign count = cnt_q;
  assign ovf   = inc && (cnt_q == `RCADC_CNT_MAX) && (wr_en == 3'h0);

endmodule : rcadc_counter

// ### verification/rcadc_chk.sv
// port assertions of the rc oscillation converter core
// assumes an apb master that holds paddr and pwdata until pready
`include "rcadc_consts.svh"
module rcadc_chk
  import rcadc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        osc_monitor_out,
  input wire rcadc_pins_s osc_pins,
  input wire logic        converter_irq
);
  logic [15:0] idx;
  logic        wr;
  logic [7:0]  mode_q;

  assign idx = paddr[17:2];
  assign wr  = psel && penable && pready && pwrite;

  // mirror of the mode register, fed by completed writes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `RCADC_REG_RESET;
    end else if (wr && idx == `RCADC_IDX_MODE) begin
      mode_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  sequence s_en_off;
    wr && idx == `RCADC_IDX_IRQ_EN && pwdata[1:0] == 2'h0;
  endsequence
  sequence s_clr_all;
    wr && idx == `RCADC_IDX_IRQ_CLR && pwdata[1:0] == 2'h3;
  endsequence
  sequence s_run_off;
    wr && idx == `RCADC_IDX_CTRL && !pwdata[`RCADC_RUN_BIT];
  endsequence

  property p_wait; s_setup |=> s_answer; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  property p_lane; pready |-> prdata[31:8] == 24'h0; endproperty
  property p_err;
    pready |-> pslverr == !(idx inside {[`RCADC_IDX_REF0:`RCADC_IDX_REF2],
      [`RCADC_IDX_OSC0:`RCADC_IDX_OSC2], [`RCADC_IDX_MODE:`RCADC_IDX_IRQ_CLR]});
  endproperty
  property p_mode;
    pready && !pwrite && idx == `RCADC_IDX_MODE |-> prdata[7:0] == mode_q;
  endproperty
  property p_mask; s_en_off |-> ##[1:2] !converter_irq; endproperty
  property p_clr; s_clr_all |-> ##[1:2] !converter_irq; endproperty
  property p_stop;
    s_run_off |-> ##3 (!osc_monitor_out && osc_pins == '0);
  endproperty

  a_wait: assert property (p_wait) else $error("pready not after one wait");
  a_one: assert property (p_one) else $error("pready longer than one cycle");
  a_idle: assert property (p_idle) else $error("prdata set outside answer");
  a_lane: assert property (p_lane) else $error("prdata upper bits set");
  a_err: assert property (p_err) else $error("pslverr against the map");
  a_mode: assert property (p_mode) else $error("mode read differs");
  a_mask: assert property (p_mask) else $error("irq stays when masked");
  a_clr: assert property (p_clr) else $error("irq stays after clear");
  a_stop: assert property (p_stop) else $error("pins or monitor after stop");
endmodule : rcadc_chk

bind rcadc_top rcadc_chk i_rcadc_chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .osc_monitor_out(osc_monitor_out), .osc_pins(osc_pins),
  .converter_irq(converter_irq)
);

// ### verification/rcadc_osc_model.sv
// behavioural oscillator network and clock sources at the far side
// assumes the core drives osc_pins high for each pin it activates
module rcadc_osc_model
  import rcadc_pkg::*;
(
  input wire rcadc_pins_s osc_pins,
  output logic            base_count_clock,
  output logic            rc_osc_clock,
  output logic            ch0_ext_clock_in,
  output logic            ch1_ext_clock_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // clocks, offset so that no edge meets a pclk edge
  // ----------------------------------------------------------------------
  initial begin
    base_count_clock = 1'h0;
    rc_osc_clock     = 1'h0;
    ch0_ext_clock_in = 1'h0;
    ch1_ext_clock_in = 1'h0;
    #13;
    forever begin
      #80;
      base_count_clock = ~base_count_clock;
      ch0_ext_clock_in = ~ch0_ext_clock_in;
      ch1_ext_clock_in = ~ch1_ext_clock_in;
      // the rc loop only oscillates while some pin is driven
      rc_osc_clock = (osc_pins != '0) ? ~rc_osc_clock : 1'h0;
    end
  end
endmodule : rcadc_osc_model

// ### verification/tb_rcadc_top.sv
// self-checking bench of the converter core over apb
// assumes rcadc_osc_model stands for the analogue network
`include "rcadc_consts.svh"
module tb_rcadc_top
  import rcadc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] R0 = `RCADC_IDX_REF0;
  localparam logic [15:0] O0 = `RCADC_IDX_OSC0;
  localparam logic [15:0] MD = `RCADC_IDX_MODE;
  localparam logic [15:0] CT = `RCADC_IDX_CTRL;

  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        clk_en = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, err_q, osc_monitor_out, converter_irq;
  logic        base_count_clock, rc_osc_clock, ch0_ext_clock_in, ch1_ext_clock_in;
  rcadc_pins_s osc_pins;
  int          n_fail = 0;
  int          comparisons = 0;

  always #4 pclk = ~pclk;

  rcadc_top i_rcadc_top (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .base_count_clock(base_count_clock), .rc_osc_clock(rc_osc_clock),
    .ch0_ext_clock_in(ch0_ext_clock_in), .ch1_ext_clock_in(ch1_ext_clock_in),
    .osc_monitor_out(osc_monitor_out), .osc_pins(osc_pins),
    .converter_irq(converter_irq)
  );
  rcadc_osc_model i_rcadc_osc_model (
    .osc_pins(osc_pins), .base_count_clock(base_count_clock),
    .rc_osc_clock(rc_osc_clock), .ch0_ext_clock_in(ch0_ext_clock_in),
    .ch1_ext_clock_in(ch1_ext_clock_in)
  );

  // ----------------------------------------------------------------------
  // bus and report tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // pready and prdata are taken at the rising edge that ends the access, then released
  task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= {i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 64);
    if (pready !== 1'h1) begin
      n_fail++;
      close_out();
    end
    q     = prdata[7:0];
    err_q = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    logic [7:0] q;
    apb(1'h1, i, d, q);
  endtask : wr

  task automatic rd(input logic [15:0] i, output logic [7:0] q);
    apb(1'h0, i, 8'h00, q);
  endtask : rd

  task automatic wr_cnt(input logic [15:0] b, input logic [23:0] v);
    for (int i = 0; i < 3; i++) wr(b + 16'(i), v[8*i +: 8]);
  endtask : wr_cnt

  task automatic rd_cnt(input logic [15:0] b, output logic [23:0] v);
    logic [7:0] q;
    for (int i = 0; i < 3; i++) begin
      rd(b + 16'(i), q);
      v[8*i +: 8] = q;
    end
  endtask : rd_cnt

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] q;
    for (int i = 0; i < 10; i++) begin
      rd(i < 3 ? R0 + 16'(i) : i < 6 ? O0 + 16'(i - 3) : MD + 16'(i - 6), q);
      chk("reset value", 8'h00, q);
    end
    chk("irq after reset", 1'h0, converter_irq);
    $display("test reset done");
  endtask : t_reset

  task automatic t_access();
    logic [7:0]  q;
    logic [23:0] v;
    wr_cnt(R0, 24'hA5C33C);
    wr_cnt(O0, 24'h5A1EE1);
    wr(MD, 8'hB6);
    repeat (40) @(posedge pclk);
    rd_cnt(R0, v);
    chk("reference bytes", 24'hA5C33C, v);
    rd_cnt(O0, v);
    chk("oscillator bytes", 24'h5A1EE1, v);
    rd(MD, q);
    chk("mode register", 8'hB6, q);
    chk("mapped error flag", 1'h0, err_q);
    rd(16'hF307, q);
    chk("unmapped data", 8'h00, q);
    chk("unmapped error flag", 1'h1, err_q);
    $display("test access done");
  endtask : t_access

  task automatic t_hold();
    logic [23:0] v;
    wr_cnt(R0, 24'h000100);
    wr_cnt(O0, 24'h000200);
    wr(MD, 8'h01);
    wr(CT, 8'h01);
    repeat (400) @(posedge pclk);
    rd_cnt(R0, v);
    chk("reference image while running", 24'h000100, v);
    rd_cnt(O0, v);
    chk("oscillator image while running", 24'h000200, v);
    wr(CT, 8'h00);
    rd_cnt(R0, v);
    chk("reference counted", 1'h1, v > 24'h000100 && v < 24'h00011F);
    rd_cnt(O0, v);
    chk("oscillator counted", 1'h1, v > 24'h000200 && v < 24'h00021F);
    $display("test hold done");
  endtask : t_hold

  // k 0: reference overflow, k 1: oscillator overflow, k 2: reference, masked
  task automatic t_ovf();
    logic [7:0]  q;
    logic [23:0] v;
    int          n;
    for (int k = 0; k < 3; k++) begin
      wr(`RCADC_IDX_IRQ_EN, k == 2 ? 8'h00 : 8'h03);
      wr_cnt(k == 1 ? O0 : R0, 24'hFFFFF8);
      wr_cnt(k == 1 ? R0 : O0, 24'h000000);
      wr(MD, k == 1 ? 8'h11 : 8'h01);
      wr(CT, 8'h01);
      n = 0;
      while (converter_irq !== 1'h1 && n < 1000) begin
        @(negedge pclk);
        n++;
      end
      if (k != 2 && n >= 1000) begin
        n_fail++;
        close_out();
      end
      chk("irq raised", k != 2, converter_irq);
      rd(CT, q);
      chk("run cleared", 1'h0, q[0]);
      rd(`RCADC_IDX_STATUS, q);
      chk("status", 8'h03, q);
      rd_cnt(k == 1 ? O0 : R0, v);
      chk("wrapped count", 24'h000000, v);
      wr(`RCADC_IDX_IRQ_CLR, 8'h03);
      rd(`RCADC_IDX_STATUS, q);
      chk("status cleared", 8'h00, q);
      chk("irq cleared", 1'h0, converter_irq);
    end
    $display("test overflow done");
  endtask : t_ovf

  task automatic t_modes();
    logic [7:0] q;
    logic       seen;
    for (int m = 0; m < 9; m++) begin
      wr_cnt(O0, 24'h000000);
      wr(MD, 8'(m));
      wr(CT, 8'h01);
      seen = 1'h0;
      repeat (300) begin
        @(negedge pclk);
        seen |= osc_monitor_out;
      end
      wr(CT, 8'h00);
      rd(O0, q);
      chk("mode counts", m < 8, q != 8'h00);
      if (m < 8) chk("monitor waveform", 1'h1, seen);
    end
    $display("test modes done");
  endtask : t_modes

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_access();
    t_hold();
    t_ovf();
    t_modes();
    close_out();
  end
endmodule : tb_rcadc_top
